// *** hw/spdsel_pkg.sv ***
// constants and types for the speed command selector
package spdsel_pkg;
    localparam int SPD_W = 14;
    typedef logic [SPD_W-1:0] spdsel_speed_t;
    localparam spdsel_speed_t SENTINEL = 14'h270F;
    localparam spdsel_speed_t RATED_CEIL = 14'h0BB8;
    localparam spdsel_speed_t RANGE_HI_SMALL = 14'h2EE0;
    localparam spdsel_speed_t RANGE_HI_LARGE = 14'h1F40;
    localparam spdsel_speed_t DEF_HIGH = 14'h0BB8;
    localparam spdsel_speed_t DEF_MID = 14'h05DC;
    localparam spdsel_speed_t DEF_LOW = 14'h012C;
    localparam spdsel_speed_t ZERO_SPEED = 14'h0000;
    localparam int NUM_BANDS = 3;
    localparam int NUM_EXT = 12;
    localparam logic [3:0] CODE_EIGHT = 4'h8;
    localparam logic [3:0] CODE_FIRST_EXT = 4'h4;
    localparam logic [3:0] PRESET_IDX_W = 4'h4;
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_JOG = 3'b001,
        SRC_MULTI = 3'b010,
        SRC_ANALOG4 = 3'b011,
        SRC_ANALOG2 = 3'b100,
        SRC_MIN = 3'b101
    } spdsel_src_t;
endpackage

// *** hw/spdsel_band_if.sv ***
// carries one jump band between selector and band checker
`timescale 1ns/1ns
`default_nettype none
interface spdsel_band_if;
    logic [13:0] edge_a;
    logic [13:0] edge_b;
    logic [13:0] speed_in;
    logic hit;
    modport owner(output edge_a, output edge_b, output speed_in, input hit);
    modport checker_side(input edge_a, input edge_b, input speed_in,
        output hit);
endinterface
`default_nettype wire

// *** hw/spdsel_band.sv ***
// one speed-jump band membership test
`timescale 1ns/1ns
`default_nettype none
module spdsel_band (
    spdsel_band_if.checker_side bus
);
    logic [13:0] lo;
    logic [13:0] hi;
    logic enabled;
    always_comb begin
        enabled = (bus.edge_a != spdsel_pkg::SENTINEL) &&
            (bus.edge_b != spdsel_pkg::SENTINEL);
        lo = (bus.edge_a < bus.edge_b) ? bus.edge_a : bus.edge_b;
        hi = (bus.edge_a < bus.edge_b) ? bus.edge_b : bus.edge_a;
        bus.hit = enabled && (bus.speed_in >= lo) &&
            (bus.speed_in <= hi);
    end
endmodule
`default_nettype wire

// *** hw/spdsel_top.sv ***
// speed command selector: presets, source priority, jumps, clamping
// Contract
// - start alone runs toward minimum when minimum is at or above start
// - three independent jump bands, either edge order
// - sentinel boundary disables its jump band
// - target in band becomes band's A edge
// - ramping speed may cross jump bands
// - store high settings, clamp target speed
// - setting range depends on drive capacity
// - high, mid, low inputs pick their presets
// - basic presets reset to defaults
// - four inputs pick presets four to fifteen
// - in-range preset writes to index 1 to 15 accepted, ignoring protect
// - among basic inputs mid wins over low, low over high
// - extension alone with speed eight unset: low
// - jog over multi-speed over analog inputs
`timescale 1ns/1ns
`default_nettype none
module spdsel_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_select_high,
    input wire logic i_select_mid,
    input wire logic i_select_low,
    input wire logic i_select_extend,
    input wire logic i_jog_select,
    input wire logic [13:0] i_jog_speed,
    input wire logic i_analog4_valid,
    input wire logic [13:0] i_analog4_speed,
    input wire logic i_analog2_valid,
    input wire logic [13:0] i_analog2_speed,
    input wire logic i_start,
    input wire logic i_large_capacity,
    input wire logic i_parameter_write_protect,
    input wire logic i_preset_wr,
    input wire logic [3:0] i_preset_idx,
    input wire logic [13:0] i_preset_data,
    input wire logic i_jump_wr,
    input wire logic [2:0] i_jump_idx,
    input wire logic [13:0] i_jump_data,
    input wire logic [13:0] i_minimum_speed_setting,
    input wire logic [13:0] i_starting_speed_setting,
    input wire logic [13:0] i_maximum_speed_setting,
    input wire logic [13:0] i_running_speed,
    output logic [13:0] o_target_speed,
    output logic o_target_valid,
    output logic [2:0] o_source,
    output logic o_jump_active,
    output logic o_running_in_band,
    output logic o_clamped,
    output logic o_write_reject
);
    localparam int NUM_B = spdsel_pkg::NUM_BANDS;
    // preset index 1=high 2=mid 3=low, 4..15 extended
    logic [13:0] preset_reg [0:15];
    logic [13:0] preset_next [0:15];
    logic [13:0] jump_reg [0:5];
    logic [13:0] jump_next [0:5];
    logic [3:0] sel_reg;
    logic [3:0] sel_next;
    logic [13:0] target_reg;
    logic [13:0] target_next;
    logic valid_reg;
    logic valid_next;
    logic [2:0] src_reg;
    logic [2:0] src_next;
    logic jump_act_reg;
    logic jump_act_next;
    logic run_band_reg;
    logic run_band_next;
    logic clamp_reg;
    logic clamp_next;
    logic rej_reg;
    logic rej_next;
    logic [13:0] raw_speed;
    logic raw_valid;
    logic [2:0] raw_src;
    logic [13:0] range_hi;
    logic [13:0] limited;
    logic [13:0] jumped;
    logic [NUM_B-1:0] cmd_hit;
    logic [NUM_B-1:0] run_hit;
    logic [3:0] code;
    logic [3:0] combo_idx;
    logic combo_set;

    spdsel_band_if cmd_if [NUM_B] ();
    spdsel_band_if run_if [NUM_B] ();
    genvar g;
    generate
        for (g = 0; g < NUM_B; g++) begin : g_band
            assign cmd_if[g].edge_a = jump_reg[2*g];
            assign cmd_if[g].edge_b = jump_reg[2*g+1];
            assign cmd_if[g].speed_in = limited;
            assign cmd_hit[g] = cmd_if[g].hit;
            assign run_if[g].edge_a = jump_reg[2*g];
            assign run_if[g].edge_b = jump_reg[2*g+1];
            assign run_if[g].speed_in = i_running_speed;
            assign run_hit[g] = run_if[g].hit;
            spdsel_band u_cmd (.bus(cmd_if[g]));
            spdsel_band u_run (.bus(run_if[g]));
        end
    endgenerate

    // parameter storage; protect input deliberately ignored for presets
    always_comb begin
        range_hi = i_large_capacity ? spdsel_pkg::RANGE_HI_LARGE :
            spdsel_pkg::RANGE_HI_SMALL;
        for (int i = 0; i < 16; i++) begin
            preset_next[i] = preset_reg[i];
        end
        for (int j = 0; j < 6; j++) begin
            jump_next[j] = jump_reg[j];
        end
        rej_next = 1'b0;
        if (i_preset_wr) begin
            // accepted running or not, protect ignored
            if (i_preset_idx == 4'h0) begin
                rej_next = 1'b1;
            end else if (i_preset_data <= range_hi ||
                (i_preset_idx >= spdsel_pkg::CODE_FIRST_EXT &&
                i_preset_data == spdsel_pkg::SENTINEL)) begin
                preset_next[i_preset_idx] = i_preset_data;
            end else begin
                rej_next = 1'b1;
            end
        end
        if (i_jump_wr) begin
            if (i_jump_idx > 3'h5) begin
                rej_next = 1'b1;
            end else if (i_jump_data <= range_hi ||
                i_jump_data == spdsel_pkg::SENTINEL) begin
                jump_next[i_jump_idx] = i_jump_data;
            end else begin
                rej_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 16; i++) begin
                preset_reg[i] <= spdsel_pkg::SENTINEL;
            end
            preset_reg[0] <= spdsel_pkg::ZERO_SPEED;
            preset_reg[1] <= spdsel_pkg::DEF_HIGH;
            preset_reg[2] <= spdsel_pkg::DEF_MID;
            preset_reg[3] <= spdsel_pkg::DEF_LOW;
            for (int j = 0; j < 6; j++) begin
                jump_reg[j] <= spdsel_pkg::SENTINEL;
            end
            rej_reg <= 1'b0;
        end else begin
            preset_reg <= preset_next;
            jump_reg <= jump_next;
            rej_reg <= rej_next;
        end
    end

    // two or three basic inputs pick speeds four to seven; an unset
    // entry falls back to the mid-over-low-over-high pick below
    always_comb begin
        combo_idx = 4'h0;
        case (sel_reg[2:0])
            3'b110: begin
                combo_idx = 4'h4;
            end
            3'b101: begin
                combo_idx = 4'h5;
            end
            3'b011: begin
                combo_idx = 4'h6;
            end
            3'b111: begin
                combo_idx = 4'h7;
            end
            default: begin
                combo_idx = 4'h0;
            end
        endcase
        combo_set = (combo_idx != 4'h0) &&
            (preset_reg[combo_idx] != spdsel_pkg::SENTINEL);
    end

    // select code: bit0 high, bit1 mid, bit2 low, bit3 extend
    always_comb begin
        sel_next = {i_select_extend, i_select_low, i_select_mid,
            i_select_high};
        code = sel_reg;
        raw_speed = spdsel_pkg::ZERO_SPEED;
        raw_valid = 1'b0;
        raw_src = spdsel_pkg::SRC_NONE;
        if (i_jog_select) begin
            raw_speed = i_jog_speed;
            raw_valid = 1'b1;
            raw_src = spdsel_pkg::SRC_JOG;
        end else if (code != 4'h0) begin
            raw_valid = 1'b1;
            raw_src = spdsel_pkg::SRC_MULTI;
            if (!code[3]) begin
                // mid wins over high and low, low wins over high
                if (code[1]) begin
                    raw_speed = preset_reg[2];
                end else if (code[2]) begin
                    raw_speed = preset_reg[3];
                end else begin
                    raw_speed = preset_reg[1];
                end
                if (code[1] && code[2]) begin
                    raw_speed = preset_reg[2];
                end
                if (combo_set) begin
                    raw_speed = preset_reg[combo_idx];
                end
            end else if (code == spdsel_pkg::CODE_EIGHT &&
                preset_reg[code] == spdsel_pkg::SENTINEL) begin
                raw_speed = preset_reg[3];
            end else if (preset_reg[code] != spdsel_pkg::SENTINEL) begin
                raw_speed = preset_reg[code];
            end else begin
                raw_valid = 1'b0;
                raw_src = spdsel_pkg::SRC_NONE;
            end
        end else if (i_analog4_valid) begin
            raw_speed = i_analog4_speed;
            raw_valid = 1'b1;
            raw_src = spdsel_pkg::SRC_ANALOG4;
        end else if (i_analog2_valid) begin
            raw_speed = i_analog2_speed;
            raw_valid = 1'b1;
            raw_src = spdsel_pkg::SRC_ANALOG2;
        end
        if (!raw_valid && i_start &&
            i_minimum_speed_setting >= i_starting_speed_setting) begin
            raw_speed = i_minimum_speed_setting;
            raw_valid = 1'b1;
            raw_src = spdsel_pkg::SRC_MIN;
        end
        // clamp: min (not for jog), max, rated ceiling
        limited = raw_speed;
        clamp_next = 1'b0;
        if (raw_src != spdsel_pkg::SRC_JOG &&
            limited < i_minimum_speed_setting && raw_valid) begin
            limited = i_minimum_speed_setting;
        end
        if (limited > i_maximum_speed_setting) begin
            limited = i_maximum_speed_setting;
            clamp_next = 1'b1;
        end
        if (limited > spdsel_pkg::RATED_CEIL) begin
            limited = spdsel_pkg::RATED_CEIL;
            clamp_next = 1'b1;
        end
        // first band in order wins when bands overlap
        jumped = limited;
        jump_act_next = 1'b0;
        for (int b = NUM_B - 1; b >= 0; b--) begin
            if (cmd_hit[b] && raw_valid) begin
                jumped = jump_reg[2*b];
                jump_act_next = 1'b1;
            end
        end
        if (jumped > spdsel_pkg::RATED_CEIL) begin
            jumped = spdsel_pkg::RATED_CEIL;
        end
        target_next = raw_valid ? jumped : spdsel_pkg::ZERO_SPEED;
        valid_next = raw_valid;
        src_next = raw_src;
        // running speed is only reported, never altered by jumps
        run_band_next = |run_hit;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_reg <= 4'h0;
            target_reg <= spdsel_pkg::ZERO_SPEED;
            valid_reg <= 1'b0;
            src_reg <= spdsel_pkg::SRC_NONE;
            jump_act_reg <= 1'b0;
            run_band_reg <= 1'b0;
            clamp_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            target_reg <= target_next;
            valid_reg <= valid_next;
            src_reg <= src_next;
            jump_act_reg <= jump_act_next;
            run_band_reg <= run_band_next;
            clamp_reg <= clamp_next;
        end
    end

    assign o_target_speed = target_reg;
    assign o_target_valid = valid_reg;
    assign o_source = src_reg;
    assign o_jump_active = jump_act_reg;
    assign o_running_in_band = run_band_reg;
    assign o_clamped = clamp_reg;
    assign o_write_reject = rej_reg;
endmodule
`default_nettype wire

// *** testbench/spdsel_contact_model.sv ***
// contact switch bank feeding the four select inputs
`timescale 1ns/1ns
`default_nettype none
module spdsel_contact_model (
    input wire logic i_clk,
    input wire logic [3:0] i_press,
    output logic o_low,
    output logic o_mid,
    output logic o_high,
    output logic o_extend
);
    // contacts move just after an edge so the selector never races them
    always @(posedge i_clk) begin
        {o_extend, o_high, o_mid, o_low} <= #1 i_press;
    end
endmodule
`default_nettype wire

// *** testbench/spdsel_sva.sv ***
// assertions on the speed selector top ports
`timescale 1ns/1ns
`default_nettype none
module spdsel_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_select_mid,
    input wire logic i_select_extend,
    input wire logic i_jog_select,
    input wire logic i_start,
    input wire logic i_large_capacity,
    input wire logic i_preset_wr,
    input wire logic [3:0] i_preset_idx,
    input wire logic [13:0] i_preset_data,
    input wire logic i_jump_wr,
    input wire logic [13:0] o_target_speed,
    input wire logic o_target_valid,
    input wire logic [2:0] o_source,
    input wire logic o_write_reject
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_jog_held;
        i_jog_select [*3];
    endsequence
    sequence s_mid_held;
        (i_select_mid && !i_select_extend && !i_jog_select) [*3];
    endsequence
    a_jog_wins: assert property (
        s_jog_held |-> o_source == 3'h1)
        else $error("jog source not chosen");
    a_multi_beats_analog: assert property (
        s_mid_held |-> o_source == 3'h2)
        else $error("multi-speed source not chosen");
    a_ceiling_held: assert property (
        o_target_valid |-> o_target_speed <= 14'h0BB8)
        else $error("target above ceiling");
    a_zero_idx_reject: assert property (
        i_preset_wr && i_preset_idx == 4'h0 |=> o_write_reject)
        else $error("index zero write not refused");
    a_range_reject: assert property (
        i_preset_wr && i_large_capacity && i_preset_data > 14'h1F40 &&
        i_preset_data != 14'h270F |=> o_write_reject)
        else $error("out of range write not refused");
    a_write_accept: assert property (
        i_preset_wr && !i_jump_wr && i_preset_idx != 4'h0 &&
        i_preset_data <= 14'h1F40 |=> !o_write_reject)
        else $error("legal preset write refused");
    a_min_cause: assert property (
        o_source == 3'h5 |-> $past(i_start))
        else $error("minimum run without start");
    a_valid_source: assert property (
        o_target_valid |-> o_source != 3'h0)
        else $error("valid target without source");
endmodule
bind spdsel_top spdsel_sva i_spdsel_sva (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_select_mid(i_select_mid),
    .i_select_extend(i_select_extend),
    .i_jog_select(i_jog_select), .i_start(i_start),
    .i_large_capacity(i_large_capacity), .i_preset_wr(i_preset_wr),
    .i_preset_idx(i_preset_idx), .i_preset_data(i_preset_data),
    .i_jump_wr(i_jump_wr), .o_target_speed(o_target_speed),
    .o_target_valid(o_target_valid), .o_source(o_source),
    .o_write_reject(o_write_reject));
`default_nettype wire

// *** testbench/test_spdsel_top.sv ***
// self-checking bench for the speed command selector
`timescale 1ns/1ns
`default_nettype none
module test_spdsel_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] press = 4'h0;
    logic jog = 1'b0, a4v = 1'b0, a2v = 1'b0, start = 1'b0;
    logic cap = 1'b0, prot = 1'b0, pwr = 1'b0, jwr = 1'b0;
    logic [3:0] pidx = 4'h0;
    logic [2:0] jidx = 3'h0;
    logic [13:0] pdat = 14'h0000, jdat = 14'h0000, mins = 14'h0000;
    logic [13:0] stas = 14'h0064, maxs = 14'h2EE0, run = 14'h0000;
    logic [13:0] jspd = 14'h0258, a4s = 14'h0320, a2s = 14'h0190;
    wire logic s_hi, s_mid, s_lo, s_ext, val, jact, inb, clmp, rej;
    wire logic [13:0] tgt;
    wire logic [2:0] src;
    int error_cnt = 0, checks_done = 0;
    logic [3:0] pr [5] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h5};
    logic [13:0] ex [5] = '{14'h012C, 14'h05DC, 14'h0BB8, 14'h05DC, 14'h012C};
    initial forever #4 clk = ~clk;
    spdsel_contact_model i_spdsel_contact_model (.i_clk(clk), .i_press(press),
        .o_low(s_lo), .o_mid(s_mid), .o_high(s_hi), .o_extend(s_ext));
    spdsel_top i_spdsel_top (.i_clk_sys(clk), .i_rst_b(rst_b),
        .i_select_high(s_hi), .i_select_mid(s_mid), .i_select_low(s_lo),
        .i_select_extend(s_ext), .i_jog_select(jog), .i_jog_speed(jspd),
        .i_analog4_valid(a4v), .i_analog4_speed(a4s), .i_analog2_valid(a2v),
        .i_analog2_speed(a2s), .i_start(start), .i_large_capacity(cap),
        .i_parameter_write_protect(prot), .i_preset_wr(pwr),
        .i_preset_idx(pidx), .i_preset_data(pdat), .i_jump_wr(jwr),
        .i_jump_idx(jidx), .i_jump_data(jdat), .i_minimum_speed_setting(mins),
        .i_starting_speed_setting(stas), .i_maximum_speed_setting(maxs),
        .i_running_speed(run), .o_target_speed(tgt), .o_target_valid(val),
        .o_source(src), .o_jump_active(jact), .o_running_in_band(inb),
        .o_clamped(clmp), .o_write_reject(rej));
    task tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string n, input logic [13:0] s, input logic [13:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %0d seen %0d", n, e, s);
        end
    endtask
    task sel(input logic [3:0] p);
        press = p;
        tk(4);
    endtask
    // write, look at the refusal pulse one edge later, then idle an edge
    task wr(input logic [3:0] i, input logic [13:0] d, input logic r);
        pidx = i;
        pdat = d;
        pwr = 1'b1;
        tk(1);
        chk("reject", rej, r);
        pwr = 1'b0;
        tk(1);
    endtask
    task jw(input logic [2:0] i, input logic [13:0] d, input logic r);
        jidx = i;
        jdat = d;
        jwr = 1'b1;
        tk(1);
        chk("jreject", rej, r);
        jwr = 1'b0;
        tk(1);
    endtask
    task done(input string n);
        $display("test %s done", n);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        tk(16);
        rst_b = 1'b1;
        for (int k = 0; k < 5; k++) begin
            sel(pr[k]);
            chk("preset", tgt, ex[k]);
        end
        chk("source", src, 3'h2);
        wr(4'h7, 14'h02BC, 1'b0);
        sel(4'h7);
        chk("combo7", tgt, 14'h02BC);
        sel(4'h9);
        chk("unset", val, 1'b0);
        chk("unsrc", src, 3'h0);
        sel(4'h8);
        chk("ext8", tgt, 14'h012C);
        chk("valid", val, 1'b1);
        done("presets");
        prot = 1'b1;
        wr(4'h8, 14'h04B0, 1'b0);
        chk("ext8w", tgt, 14'h04B0);
        wr(4'h0, 14'h0064, 1'b1);
        wr(4'h1, 14'h32C8, 1'b1);
        cap = 1'b1;
        wr(4'h2, 14'h2328, 1'b1);
        wr(4'h2, 14'h1F40, 1'b0);
        cap = 1'b0;
        sel(4'h2);
        chk("ceil", tgt, 14'h0BB8);
        chk("clamp", clmp, 1'b1);
        done("writes");
        jw(3'h0, 14'h0578, 1'b0);
        jw(3'h1, 14'h03E8, 1'b0);
        wr(4'h2, 14'h03E8, 1'b0);
        chk("edge", tgt, 14'h0578);
        chk("jump", jact, 1'b1);
        jw(3'h4, 14'h00C8, 1'b0);
        jw(3'h2, 14'h0190, 1'b0);
        jw(3'h3, 14'h01F4, 1'b0);
        sel(4'h1);
        chk("off3", tgt, 14'h012C);
        chk("nojump", jact, 1'b0);
        wr(4'h3, 14'h01C2, 1'b0);
        chk("band2", tgt, 14'h0190);
        jw(3'h6, 14'h0064, 1'b1);
        done("jumps");
        jog = 1'b1;
        tk(3);
        chk("jog", tgt, 14'h0258);
        chk("jsrc", src, 3'h1);
        jog = 1'b0;
        a4v = 1'b1;
        a2v = 1'b1;
        sel(4'h0);
        chk("a4", src, 3'h3);
        a4v = 1'b0;
        tk(3);
        chk("a2", src, 3'h4);
        a2v = 1'b0;
        start = 1'b1;
        mins = 14'h0190;
        run = 14'h0514;
        tk(3);
        chk("msrc", src, 3'h5);
        chk("min", tgt, 14'h0190);
        chk("ramp", inb, 1'b1);
        done("sources");
        end_of_test;
    end
endmodule
`default_nettype wire
